/* common/sdram_prot_map.svh */
// Purpose: Register offsets, field positions and reset values of the access checker
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Included by the checker module only
`ifndef SDRAM_PROT_MAP_SVH
`define SDRAM_PROT_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_RULE_SEL 8'h00
`define OFS_RULE_CTRL 8'h04
`define OFS_RULE_ID 8'h08
`define OFS_RULE_ADDR 8'h0C
`define OFS_PORT_DEFAULT 8'h10
`define OFS_PORT_FORCE 8'h14
`define OFS_STATUS 8'h18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define POS_VALID 0
`define POS_FAIL 1
`define POS_PROT 2
`define POS_PORT_MASK 4
`define POS_UPPER 16
`define POS_FORCE_FAIL 16
`define POS_RES_COUNT 0
`define POS_REJECTS 8

// ----------------------------------------
// Sizes and reset values
// ----------------------------------------
`define RULE_COUNT 20
`define RES_COUNT 16
`define PORT_COUNT 10
`define RST_PORT_DEFAULT 10'h000
`define RST_LFSR 16'hACE1

`endif

/* common/sdram_prot_pkg.sv */
// Purpose: Types shared by the access checker and its bench
// Assumes: Map header gives sizes and offsets
// Notes: Port numbers 0-5 fabric, 6 interconnect read, 7 cpu read, 8 interconnect write,
//        9 cpu write
package sdram_prot_pkg;

    typedef struct packed {
        logic write;
        logic excl;
        logic prot;
        logic [3:0] port;
        logic [11:0] id;
        logic [31:0] addr;
    } req_t;

    typedef struct packed {
        logic valid;
        logic fail;
        logic [1:0] prot;
        logic [9:0] port_mask;
        logic [11:0] id_lower_bound;
        logic [11:0] id_upper_bound;
        logic [11:0] addr_lower;
        logic [11:0] addr_upper;
    } rule_t;

    typedef enum logic [1:0] {
        RESP_OKAY,
        RESP_EXOKAY,
        RESP_EXFAIL,
        RESP_ERROR
    } resp_code_t;

    typedef struct packed {
        logic [3:0] port;
        logic [11:0] id;
        resp_code_t code;
    } resp_t;

endpackage : sdram_prot_pkg

/* logic/sdram_access_protection.sv */
// Purpose: Protection rule check and shared exclusive monitor in front of the scheduler
// Assumes: One request per cycle from the port arbiter, same clock as this block
// Notes: Rule table reached indirectly through the APB select register
`timescale 1ns/10ps
`include "sdram_prot_map.svh"

module sdram_access_protection (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic req_valid,
    input wire sdram_prot_pkg::req_t req,
    output logic req_ready,
    output logic sched_valid,
    output sdram_prot_pkg::req_t sched_req,
    input wire logic sched_ready,
    output logic resp_valid,
    output sdram_prot_pkg::resp_t resp
);
    import sdram_prot_pkg::*;

    // ----------------------------------------
    // Matching helpers
    // ----------------------------------------
    function automatic logic [9:0] port_bit(input logic [3:0] port);
        logic [9:0] sel;
        sel = 10'h000;
        if (port < 4'hA) begin
            sel[port] = 1'b1;
        end
        return sel;
    endfunction : port_bit

    function automatic logic rule_hit(input rule_t r, input req_t q);
        logic [11:0] blk;
        blk = q.addr[31:20];
        return r.valid
            && ((r.port_mask & port_bit(q.port)) != 10'h000)
            && (q.id >= r.id_lower_bound)
            && (q.id <= r.id_upper_bound)
            && (blk >= r.addr_lower)
            && (blk <= r.addr_upper)
            && (r.prot == {1'b0, q.prot});
    endfunction : rule_hit

    // ----------------------------------------
    // State
    // ----------------------------------------
    rule_t rules [`RULE_COUNT];
    rule_t next_rules [`RULE_COUNT];
    logic [4:0] rule_sel, next_rule_sel;
    logic [9:0] port_default, next_port_default;
    logic [9:0] force_allow, next_force_allow;
    logic [9:0] force_fail, next_force_fail;
    logic [7:0] reject_count, next_reject_count;
    logic res_v [`RES_COUNT];
    logic next_res_v [`RES_COUNT];
    logic [28:0] res_addr [`RES_COUNT];
    logic [28:0] next_res_addr [`RES_COUNT];
    logic [15:0] lfsr, next_lfsr;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic next_sched_valid, next_resp_valid;
    req_t next_sched_req;
    resp_t next_resp;

    // ----------------------------------------
    // Rule evaluation
    // ----------------------------------------
    logic [`RULE_COUNT-1:0] hit_fail, hit_allow;
    logic [`RES_COUNT-1:0] res_hit;
    genvar gi;
    generate
        for (gi = 0; gi < `RULE_COUNT; gi++) begin : g_rule
            // Every rule is compared in parallel, no priority among them
            assign hit_fail[gi] = rule_hit(rules[gi], req) && rules[gi].fail;
            assign hit_allow[gi] = rule_hit(rules[gi], req) && !rules[gi].fail;
        end
        for (gi = 0; gi < `RES_COUNT; gi++) begin : g_res
            // Reservation granule is one 8-byte beat
            assign res_hit[gi] = res_v[gi] && (res_addr[gi] == req.addr[31:3]);
        end
    endgenerate

    logic [9:0] pbit;
    logic prot_ok, res_any, res_full;
    logic [3:0] free_idx;
    logic [4:0] res_used;
    logic take;
    assign pbit = port_bit(req.port);
    assign res_any = (res_hit != 16'h0000);
    assign take = req_valid && req_ready;
    // Output stage drains only when the scheduler takes the held request
    assign req_ready = !sched_valid || sched_ready;

    always_comb begin
        prot_ok = ((port_default & pbit) != 10'h000) ? (hit_allow != 20'h00000)
                                                     : (hit_fail == 20'h00000);
        if ((force_fail & pbit) != 10'h000) begin
            prot_ok = 1'b0;
        end else if ((force_allow & pbit) != 10'h000) begin
            prot_ok = 1'b1;
        end
        if (pbit == 10'h000) begin
            prot_ok = 1'b0;
        end
        res_full = 1'b1;
        free_idx = 4'h0;
        res_used = 5'h00;
        for (int i = `RES_COUNT - 1; i >= 0; i--) begin
            if (!res_v[i]) begin
                res_full = 1'b0;
                free_idx = 4'(i);
            end
            res_used = res_used + 5'(res_v[i]);
        end
    end

    // ----------------------------------------
    // Request path and exclusive monitor
    // ----------------------------------------
    always_comb begin
        next_res_v = res_v;
        next_res_addr = res_addr;
        next_lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        next_sched_valid = sched_valid && !sched_ready;
        next_sched_req = sched_req;
        next_resp_valid = 1'b0;
        next_resp = resp;
        next_reject_count = reject_count;
        if (take) begin
            next_resp.port = req.port;
            next_resp.id = req.id;
            if (req.write && req.excl) begin
                // Rule check is skipped: the earlier exclusive read already passed it
                if (res_any) begin
                    next_sched_valid = 1'b1;
                    next_sched_req = req;
                    next_resp.code = RESP_EXOKAY;
                    next_resp_valid = 1'b1;
                end else begin
                    next_resp.code = RESP_EXFAIL;
                    next_resp_valid = 1'b1;
                end
            end else if (!prot_ok) begin
                next_resp.code = RESP_ERROR;
                next_resp_valid = 1'b1;
                next_reject_count = reject_count + 8'h01;
            end else begin
                next_sched_valid = 1'b1;
                next_sched_req = req;
                if (req.excl) begin
                    next_resp.code = RESP_EXOKAY;
                    next_resp_valid = 1'b1;
                end
            end
            // Any write that goes on to memory ends every reservation on its beat
            if (req.write && (req.excl ? res_any : prot_ok)) begin
                for (int i = 0; i < `RES_COUNT; i++) begin
                    if (res_hit[i]) begin
                        next_res_v[i] = 1'b0;
                    end
                end
            end
            if (!req.write && req.excl && prot_ok && !res_any) begin
                // Shared by all ports, so a full table evicts at random
                if (res_full) begin
                    next_res_v[lfsr[3:0]] = 1'b1;
                    next_res_addr[lfsr[3:0]] = req.addr[31:3];
                end else begin
                    next_res_v[free_idx] = 1'b1;
                    next_res_addr[free_idx] = req.addr[31:3];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `RES_COUNT; i++) begin
                res_v[i] <= 1'b0;
                res_addr[i] <= 29'h00000000;
            end
            lfsr <= `RST_LFSR;
            sched_valid <= 1'b0;
            sched_req <= '0;
            resp_valid <= 1'b0;
            resp <= '0;
            reject_count <= 8'h00;
        end else begin
            res_v <= next_res_v;
            res_addr <= next_res_addr;
            lfsr <= next_lfsr;
            sched_valid <= next_sched_valid;
            sched_req <= next_sched_req;
            resp_valid <= next_resp_valid;
            resp <= next_resp;
            reject_count <= next_reject_count;
        end
    end

    // ----------------------------------------
    // APB register file
    // ----------------------------------------
    logic setup, wr_en, sel_ok;
    rule_t cur;
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite;
    assign sel_ok = (rule_sel < 5'(`RULE_COUNT));
    assign cur = sel_ok ? rules[rule_sel] : '0;
    // Read data and error are sampled in setup, so no wait states are needed
    assign pready = 1'b1;

    always_comb begin
        next_rules = rules;
        next_rule_sel = rule_sel;
        next_port_default = port_default;
        next_force_allow = force_allow;
        next_force_fail = force_fail;
        next_prdata = prdata;
        next_pslverr = pslverr;
        if (setup) begin
            next_pslverr = 1'b0;
            next_prdata = 32'h00000000;
            if (paddr == `OFS_RULE_SEL) begin
                next_prdata = {27'h0000000, rule_sel};
            end else if (paddr == `OFS_RULE_CTRL) begin
                next_prdata = {18'h00000, cur.port_mask, cur.prot, cur.fail, cur.valid};
            end else if (paddr == `OFS_RULE_ID) begin
                next_prdata = {4'h0, cur.id_upper_bound, 4'h0, cur.id_lower_bound};
            end else if (paddr == `OFS_RULE_ADDR) begin
                next_prdata = {4'h0, cur.addr_upper, 4'h0, cur.addr_lower};
            end else if (paddr == `OFS_PORT_DEFAULT) begin
                next_prdata = {22'h000000, port_default};
            end else if (paddr == `OFS_PORT_FORCE) begin
                next_prdata = {6'h00, force_fail, 6'h00, force_allow};
            end else if (paddr == `OFS_STATUS) begin
                next_prdata = {16'h0000, reject_count, 3'h0, res_used};
            end else begin
                next_pslverr = 1'b1;
            end
        end
        if (wr_en) begin
            if (paddr == `OFS_RULE_SEL) begin
                next_rule_sel = pwdata[4:0];
            end else if (paddr == `OFS_RULE_CTRL && sel_ok) begin
                next_rules[rule_sel].valid = pwdata[`POS_VALID];
                next_rules[rule_sel].fail = pwdata[`POS_FAIL];
                next_rules[rule_sel].prot = pwdata[`POS_PROT +: 2];
                next_rules[rule_sel].port_mask = pwdata[`POS_PORT_MASK +: 10];
            end else if (paddr == `OFS_RULE_ID && sel_ok) begin
                next_rules[rule_sel].id_lower_bound = pwdata[11:0];
                next_rules[rule_sel].id_upper_bound = pwdata[`POS_UPPER +: 12];
            end else if (paddr == `OFS_RULE_ADDR && sel_ok) begin
                next_rules[rule_sel].addr_lower = pwdata[11:0];
                next_rules[rule_sel].addr_upper = pwdata[`POS_UPPER +: 12];
            end else if (paddr == `OFS_PORT_DEFAULT) begin
                next_port_default = pwdata[9:0];
            end else if (paddr == `OFS_PORT_FORCE) begin
                next_force_allow = pwdata[9:0];
                next_force_fail = pwdata[`POS_FORCE_FAIL +: 10];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `RULE_COUNT; i++) begin
                rules[i] <= '0;
            end
            rule_sel <= 5'h00;
            port_default <= `RST_PORT_DEFAULT;
            force_allow <= 10'h000;
            force_fail <= 10'h000;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            rules <= next_rules;
            rule_sel <= next_rule_sel;
            port_default <= next_port_default;
            force_allow <= next_force_allow;
            force_fail <= next_force_fail;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

endmodule : sdram_access_protection

/* verification/sched_model.sv */
// Purpose: Scheduler stand-in that accepts forwarded requests
// Assumes: Same clock as the checker under test
// Notes: Slow mode stalls three cycles in four to exercise back-pressure
`timescale 1ns/10ps
module sched_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    output logic sched_ready
);
    logic [1:0] cnt;
    logic [1:0] next_cnt;
    always_comb begin
        next_cnt = cnt + 2'h1;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 2'h0;
        end else begin
            cnt <= next_cnt;
        end
    end
    assign sched_ready = !slow || (cnt == 2'h0);
endmodule : sched_model

/* verification/sdram_access_protection_tb_top.sv */
// Purpose: Self-checking bench for the SDRAM access checker
// Assumes: Scheduler stand-in from sched_model, APB master in tasks below
// Notes: Random exclusive traffic kept to sixteen beats so replacement stays predictable
`timescale 1ns/10ps
module sdram_access_protection_tb_top;
    import sdram_prot_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
    logic req_valid, req_ready, sched_valid, sched_ready, resp_valid, slow;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, pdef, pfrc;
    logic [31:0] rctl[20], rid[20], radr[20];
    logic [28:0] res[$];
    req_t req, sched_req;
    resp_t resp;
    int err_count, checks, cycles, rejects;
    integer seed;

    sdram_access_protection i_sdram_access_protection (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .sched_valid(sched_valid), .sched_req(sched_req),
        .sched_ready(sched_ready), .resp_valid(resp_valid), .resp(resp));
    sched_model i_sched_model (.pclk(pclk), .presetn(presetn), .slow(slow),
        .sched_ready(sched_ready));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            summarize();
        end
    end
    // --------
    // Tasks
    // --------
    task automatic cmp(string what, logic [63:0] exp, logic [63:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic set_rule(int i, logic [31:0] c, logic [31:0] idw, logic [31:0] aw);
        rctl[i] = c;
        rid[i] = idw;
        radr[i] = aw;
        apb(1'b1, 8'h00, i);
        apb(1'b1, 8'h04, c);
        apb(1'b1, 8'h08, idw);
        apb(1'b1, 8'h0C, aw);
        apb(1'b0, 8'h04, 32'h0);
        cmp("rule ctrl", c, rd);
        apb(1'b0, 8'h08, 32'h0);
        cmp("rule id", idw, rd);
        apb(1'b0, 8'h0C, 32'h0);
        cmp("rule addr", aw, rd);
    endtask : set_rule
    // Model answer: {forwarded, answered, code}
    function automatic logic [3:0] predict(req_t r);
        logic ok;
        logic d;
        int q[$];
        q = res.find_index(x) with (x == r.addr[31:3]);
        if (r.excl && r.write) begin
            if (q.size() == 0) return 4'h6;
            res = res.find(x) with (x != r.addr[31:3]);
            return 4'hD;
        end
        ok = 1'b0;
        if (r.port <= 4'h9) begin
            d = pdef[r.port];
            ok = !d;
            for (int i = 0; i < 20; i++) begin
                if (rctl[i][0] && rctl[i][4 + r.port] && rctl[i][1] != d
                    && rctl[i][3:2] == {1'b0, r.prot} && r.id >= rid[i][11:0]
                    && r.id <= rid[i][27:16] && r.addr[31:20] >= radr[i][11:0]
                    && r.addr[31:20] <= radr[i][27:16]) ok = d;
            end
            if (pfrc[r.port]) ok = 1'b1;
            if (pfrc[16 + r.port]) ok = 1'b0;
        end
        if (!ok) return 4'h7;
        if (r.write) res = res.find(x) with (x != r.addr[31:3]);
        if (!r.excl) return 4'h8;
        if (q.size() == 0) res.push_back(r.addr[31:3]);
        return 4'hD;
    endfunction : predict
    task automatic send(req_t r);
        logic [3:0] e;
        @(posedge pclk);
        req_valid <= 1'b1;
        req <= r;
        do @(posedge pclk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        e = predict(r);
        if (e == 4'h7) rejects++;
        #1;
        cmp("sched_valid", e[3], sched_valid);
        cmp("resp_valid", e[2], resp_valid);
        if (e[2]) cmp("resp code", e[1:0], resp.code);
        if (e[3]) cmp("sched_req", r, sched_req);
    endtask : send
    function automatic req_t mk(logic w, logic e, logic [31:0] a);
        req_t r;
        r = '0;
        r.write = w;
        r.excl = e;
        r.port = 4'h9;
        r.addr = a;
        return r;
    endfunction : mk
    // Fabric ports stay off the exclusive blocks, which only ports 6 to 11 use
    function automatic req_t rnd_req();
        req_t r;
        r.port = 4'($unsigned($random(seed)) % 12);
        r.id = 12'($unsigned($random(seed)) % 16);
        r.prot = 1'($random(seed));
        r.write = 1'($random(seed));
        r.excl = r.port > 4'h5 && ($random(seed) & 3) == 0;
        r.addr = ($random(seed) & 32'h0030_0018) | (r.port < 4'h6 ? 32'h0040_0000 : 32'h0);
        return r;
    endfunction : rnd_req
    task automatic summarize();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize
    // --------
    // Sequence
    // --------
    initial begin
        seed = 62507;
        {presetn, psel, penable, pwrite, req_valid, slow} = 6'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        req = '0;
        pdef = 32'h0;
        pfrc = 32'h0;
        foreach (rctl[i]) rctl[i] = 32'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h10, 32'h0);
        cmp("default reset", 32'h0, rd);
        apb(1'b0, 8'h1C, 32'h0);
        cmp("unmapped error", 1'b1, se);
        apb(1'b1, 8'h00, 32'h14);
        apb(1'b1, 8'h04, 32'h3FFF);
        apb(1'b0, 8'h04, 32'h0);
        cmp("rule beyond table", 32'h0, rd);
        set_rule(0, 32'h0000_3FF2, 32'h0, 32'h0);
        send(mk(1'b0, 1'b0, 32'h0));
        set_rule(0, 32'h0000_3FF3, 32'h0, 32'h0);
        send(mk(1'b0, 1'b0, 32'h0));
        for (int p = 0; p < 4; p++) begin
            for (int i = 0; i < 20; i++) begin
                set_rule(i, $random(seed) & 32'h3FFF, $random(seed) & 32'h000F_000F,
                    $random(seed) & 32'h0007_0007);
            end
            pdef = $random(seed) & 32'h3FF;
            pfrc = $random(seed) & 32'h0003_0003;
            apb(1'b1, 8'h10, pdef);
            apb(1'b1, 8'h14, pfrc);
            apb(1'b0, 8'h10, 32'h0);
            cmp("port default", pdef, rd);
            apb(1'b0, 8'h14, 32'h0);
            cmp("port force", pfrc, rd);
            slow <= p[0];
            repeat (150) send(rnd_req());
            apb(1'b0, 8'h18, 32'h0);
            cmp("reservations", res.size(), rd[4:0]);
            cmp("reject count", rejects[7:0], rd[15:8]);
        end
        pfrc = 32'h0000_03FF;
        apb(1'b1, 8'h14, pfrc);
        for (int i = 0; i < 16; i++) begin
            send(mk(1'b1, 1'b0, {10'h0, i[3:2], 15'h0, i[1:0], 3'h0}));
        end
        apb(1'b0, 8'h18, 32'h0);
        cmp("reservations cleared", 32'h0, rd[4:0]);
        for (int i = 0; i < 17; i++) send(mk(1'b0, 1'b1, 32'h0100_0000 + i * 8));
        apb(1'b0, 8'h18, 32'h0);
        cmp("reservations full", 32'h10, rd[4:0]);
        send(mk(1'b1, 1'b1, 32'h0100_0080));
        for (int i = 0; i < 17; i++) send(mk(1'b1, 1'b0, 32'h0100_0000 + i * 8));
        apb(1'b0, 8'h18, 32'h0);
        cmp("reservations empty", 32'h0, rd[4:0]);
        summarize();
    end
endmodule : sdram_access_protection_tb_top

bind sdram_access_protection sdram_prot_sva i_sdram_prot_sva (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .sched_valid(sched_valid), .sched_req(sched_req),
    .sched_ready(sched_ready), .resp_valid(resp_valid), .resp(resp));

/* verification/sdram_prot_sva.sv */
// Purpose: Port-level checks of the access checker
// Assumes: One clock, asynchronous active-low reset
// Notes: Sees only the top module's ports
`timescale 1ns/10ps
module sdram_prot_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic req_valid,
    input wire sdram_prot_pkg::req_t req,
    input wire logic req_ready,
    input wire logic sched_valid,
    input wire sdram_prot_pkg::req_t sched_req,
    input wire logic sched_ready,
    input wire logic resp_valid,
    input wire sdram_prot_pkg::resp_t resp
);
    import sdram_prot_pkg::*;
    logic took;
    assign took = req_valid && req_ready;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // --------
    // Properties
    // --------
    property p_hold; sched_valid && !sched_ready |=> sched_valid && $stable(sched_req); endproperty
    a_hold: assert property (p_hold) else $error("scheduler request dropped");
    property p_fwd; took && !req.excl |=> sched_valid != resp_valid; endproperty
    a_fwd: assert property (p_fwd) else $error("plain request not one outcome");
    property p_copy; took ##1 sched_valid |-> sched_req == $past(req); endproperty
    a_copy: assert property (p_copy) else $error("forwarded request altered");
    property p_err; resp_valid && resp.code == RESP_ERROR |-> !sched_valid; endproperty
    a_err: assert property (p_err) else $error("rejected request forwarded");
    property p_exfail; resp_valid && resp.code == RESP_EXFAIL |-> !sched_valid; endproperty
    a_exfail: assert property (p_exfail) else $error("failed exclusive forwarded");
    property p_exw;
        took && req.excl && req.write |=> resp_valid && resp.code inside {RESP_EXOKAY, RESP_EXFAIL};
    endproperty
    a_exw: assert property (p_exw) else $error("exclusive write answer wrong");
    property p_exrd;
        took && req.excl && !req.write |=> resp_valid && (sched_valid == (resp.code == RESP_EXOKAY));
    endproperty
    a_exrd: assert property (p_exrd) else $error("exclusive read answer wrong");
    property p_badport;
        took && req.port > 4'h9 && !(req.excl && req.write) |=> resp_valid && resp.code == RESP_ERROR;
    endproperty
    a_badport: assert property (p_badport) else $error("unknown port accepted");
    property p_tag;
        took ##1 resp_valid |-> resp.port == $past(req.port) && resp.id == $past(req.id);
    endproperty
    a_tag: assert property (p_tag) else $error("answer tag wrong");
    property p_cause; resp_valid |-> $past(took); endproperty
    a_cause: assert property (p_cause) else $error("answer without request");
    property p_slverr; psel && !penable && paddr > 8'h18 |=> pslverr && prdata == 32'h0; endproperty
    a_slverr: assert property (p_slverr) else $error("unmapped access not refused");
endmodule : sdram_prot_sva
